// file: core/dps_pkg.sv
// Shared constants for the dual-port SRAM port controller.
// Assumes a single clock domain; included by every design file.
package dps_pkg;
    localparam int         ADDR_W_DEF    = 15;     // Word address width
    localparam int         DATA_W        = 36;     // Full word width
    localparam int         HALF_W        = 18;     // Word lane width (x18)
    localparam int         LANE_W        = 9;      // Byte lane width (x9)
    localparam int         FIFO_DEPTH    = 8;      // Write buffer depth
    localparam logic [1:0] PART_FIRST    = 2'h0;   // Lowest lane index
    localparam logic [1:0] PART_LAST_X18 = 2'h1;   // Highest lane index, x18
    localparam logic [1:0] PART_LAST_X9  = 2'h3;   // Highest lane index, x9
    localparam logic [1:0] RO_PHASE_MAX  = 2'h3;   // Readout phase saturation
    localparam int         RO_X36_LSB    = 3;      // Counter readout pin offset
    localparam int         RO_WA_BIT     = 2;      // Word-select readout pin
    localparam int         RO_BA_BIT     = 1;      // Byte-select readout pin
    localparam int         RO_X9_HI_W    = 9;      // Upper address part, x9

    // Right-port bus width
    typedef enum logic [1:0] {
        DPS_X36,
        DPS_X18,
        DPS_X9
    } dps_width_e;
endpackage

// file: core/dps_fifo.sv
// Synchronous FIFO carrying assembled write words to the array.
// Assumes DEPTH is a power of two; same clock and reset as the user.
`timescale 1ns/10ps
`default_nettype none
module dps_fifo
    import dps_pkg::*;
#(
    parameter int W     = 51,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         inValid,
    output var  logic         inReady,
    input  wire logic [W-1:0] inData,
    output var  logic         outValid,
    input  wire logic         outReady,
    output var  logic [W-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];     // Entry storage
    logic [PW-1:0] wrPtr_q, wrPtr_d; // Write index
    logic [PW-1:0] rdPtr_q, rdPtr_d; // Read index
    logic [PW:0]   cnt_q, cnt_d;     // Occupancy
    logic          push;
    logic          pop;

    assign push    = inValid && inReady;
    assign pop     = outValid && outReady;
    assign outData = mem_q[rdPtr_q];

    // Pointer and occupancy update
    always_comb begin
        wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
        cnt_d   = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    // Flags are registered so the ready seen by the source is a flop
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q  <= '0;
            rdPtr_q  <= '0;
            cnt_q    <= '0;
            inReady  <= 1'b0;
            outValid <= 1'b0;
        end else begin
            wrPtr_q  <= wrPtr_d;
            rdPtr_q  <= rdPtr_d;
            cnt_q    <= cnt_d;
            inReady  <= cnt_d != (PW+1)'(DEPTH);
            outValid <= cnt_d != '0;
        end
    end

    // Entry storage, one slot per write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end
endmodule
`default_nettype wire

// file: core/dps_array.sv
// Memory cell array of one port: combinational read, buffered write.
// Assumes the writer holds data until wrReady; hold stalls draining.
`timescale 1ns/10ps
`default_nettype none
module dps_array
    import dps_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
) (
    input  wire logic              mclk,
    input  wire logic              arrayHold,
    input  wire logic              wrValid,
    output var  logic              wrReady,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output var  logic [DATA_W-1:0] rdData
);
    logic [DATA_W-1:0] cell_q [2**ADDR_W]; // Storage cells

    assign wrReady = !arrayHold;
    assign rdData  = cell_q[rdAddr];

    // Cell write while not held off
    always_ff @(posedge mclk) begin
        if (wrValid && wrReady) begin
            cell_q[wrAddr] <= wrData;
        end
    end
endmodule
`default_nettype wire

// file: core/dps_port_ctrl.sv
// Synchronous control of one SRAM port: decode, burst counter, bus match.
// Assumes a host clocked on mclk; bidirectional data split in/out/enable.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Pipelined: select change shows one cycle later
// - Output enable high floats outputs asynchronously
// - Output state follows previous cycle's controls
// - Counter clear low resets counter every edge
// - Strobe and advance low load external address
// - Hold-read drives counter address on data pins
// - Strobe high: hold or increment by advance
// - Counter runs regardless of chip select
// - Word takes two x18 or four x9 cycles
// - Width selects choose 36, 18 or 9 data bits
// - x9 readout extends final address part
module dps_port_ctrl
    import dps_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              chipSelectN,
    input  wire logic              readWriteN,
    input  wire logic              outputEnableN,
    input  wire logic              address_strobe_n,
    input  wire logic              count_advance_n,
    input  wire logic              counter_clear_n,
    input  wire logic              bus_match_select,
    input  wire logic              widthSelect,
    input  wire logic              byte_order_select,
    input  wire logic              flow_or_pipeline_select,
    input  wire logic [ADDR_W-1:0] addrIn,
    input  wire logic [DATA_W-1:0] dqIn,
    output var  logic [DATA_W-1:0] dqOut,
    output var  logic              dqOeN,
    input  wire logic              arrayHold,
    output var  logic              writeReady
);
    localparam int FW = ADDR_W + DATA_W; // Buffered word plus address

    dps_width_e        widthMode;      // Decoded bus width
    logic [1:0]        partLast;       // Highest lane index this width
    logic [1:0]        partStart;      // First lane of a burst
    logic [1:0]        partEnd;        // Lane that completes a word
    logic              pipe;           // Pipelined output mode
    logic [ADDR_W-1:0] wordCnt_q;      // Word address counter
    logic [ADDR_W-1:0] wordCnt_d;
    logic [1:0]        partCnt_q;      // Lane sub-counter
    logic [1:0]        partCnt_d;
    logic [1:0]        roPhase_q;      // Consecutive readout cycles
    logic [1:0]        roPhase_d;
    logic [DATA_W-1:0] asm_q;          // Write word assembly
    logic [DATA_W-1:0] asm_d;
    logic [DATA_W-1:0] stage_q;        // Extra pipeline stage data
    logic [DATA_W-1:0] stage_d;
    logic              stageDrv_q;     // Extra pipeline stage drive
    logic              stageDrv_d;
    logic [DATA_W-1:0] dqOut_d;
    logic              drive_q;        // Output drive, registered
    logic              drive_d;
    logic [DATA_W-1:0] fresh;          // Value decided this edge
    logic              freshDrv;       // Drive decided this edge
    logic              roCond;         // Hold plus counter readout
    logic              writeCyc;       // Write taken this edge
    logic              wordDone;       // This write completes a word
    logic              fifoValid;
    logic              arrayReady;
    logic [FW-1:0]     fifoData;
    logic [DATA_W-1:0] rdData;

    // Width and order decode; selects are static per configuration
    always_comb begin
        pipe = flow_or_pipeline_select;
        if (bus_match_select && widthSelect) begin
            widthMode = DPS_X9;
            partLast  = PART_LAST_X9;
        end else if (bus_match_select) begin
            widthMode = DPS_X18;
            partLast  = PART_LAST_X18;
        end else begin
            widthMode = DPS_X36;
            partLast  = PART_FIRST;
        end
        partStart = byte_order_select ? partLast : PART_FIRST;
        partEnd   = byte_order_select ? PART_FIRST : partLast;
    end

    // Burst counter; chip select plays no part here
    always_comb begin
        wordCnt_d = wordCnt_q;
        partCnt_d = partCnt_q;
        if (!counter_clear_n) begin
            // Clear wins over every other input
            wordCnt_d = '0;
            partCnt_d = partStart;
        end else if (!address_strobe_n && !count_advance_n) begin
            // Load external address, used at once
            wordCnt_d = addrIn;
            partCnt_d = partStart;
        end else if (address_strobe_n && !count_advance_n) begin
            // Step lane first, carry into word when the word ends
            if (widthMode == DPS_X36 || partCnt_q == partEnd) begin
                wordCnt_d = wordCnt_q + 1'b1;
                partCnt_d = partStart;
            end else if (byte_order_select) begin
                partCnt_d = partCnt_q - 1'b1;
            end else begin
                partCnt_d = partCnt_q + 1'b1;
            end
        end
        // Otherwise hold: external address ignored
    end

    // Write decode and lane assembly into a full word
    always_comb begin
        writeCyc = !chipSelectN && !readWriteN;
        asm_d    = asm_q;
        wordDone = 1'b0;
        if (writeCyc) begin
            case (widthMode)
                DPS_X18: begin
                    asm_d[partCnt_d[0]*HALF_W +: HALF_W] = dqIn[HALF_W-1:0];
                end
                DPS_X9: begin
                    asm_d[partCnt_d*LANE_W +: LANE_W] = dqIn[LANE_W-1:0];
                end
                default: begin
                    asm_d = dqIn;
                end
            endcase
            wordDone = (widthMode == DPS_X36) || (partCnt_d == partEnd);
        end
    end

    // Readout phase counts consecutive hold-read cycles
    always_comb begin
        roCond    = counter_clear_n && !address_strobe_n && count_advance_n &&
                    readWriteN && !outputEnableN;
        roPhase_d = '0;
        if (roCond) begin
            roPhase_d = (roPhase_q == RO_PHASE_MAX) ? roPhase_q : roPhase_q + 1'b1;
        end
    end

    // Value for the data pins, decided by this edge's controls
    always_comb begin
        fresh    = '0;
        freshDrv = !chipSelectN && readWriteN;
        if (roCond) begin
            case (widthMode)
                DPS_X18: begin
                    fresh[RO_X36_LSB +: ADDR_W] = wordCnt_d;
                    fresh[RO_WA_BIT]            = partCnt_d[0];
                end
                DPS_X9: begin
                    if (roPhase_q == '0) begin
                        fresh[RO_X9_HI_W-1:0] = wordCnt_d[ADDR_W-1 -: RO_X9_HI_W];
                    end else begin
                        // Final part repeats while the hold-read stays
                        fresh[RO_X36_LSB +: ADDR_W-RO_X9_HI_W] =
                            wordCnt_d[ADDR_W-RO_X9_HI_W-1:0];
                        fresh[RO_WA_BIT] = partCnt_d[0];
                        fresh[RO_BA_BIT] = partCnt_d[1];
                    end
                end
                default: begin
                    fresh[RO_X36_LSB +: ADDR_W] = wordCnt_d;
                end
            endcase
        end else begin
            case (widthMode)
                DPS_X18: begin
                    fresh[HALF_W-1:0] = rdData[partCnt_d[0]*HALF_W +: HALF_W];
                end
                DPS_X9: begin
                    fresh[LANE_W-1:0] = rdData[partCnt_d*LANE_W +: LANE_W];
                end
                default: begin
                    fresh = rdData;
                end
            endcase
        end
    end

    // Output path: one stage flow-through, two stages pipelined
    always_comb begin
        stage_d    = fresh;
        stageDrv_d = freshDrv;
        dqOut_d    = pipe ? stage_q : fresh;
        drive_d    = pipe ? stageDrv_q : freshDrv;
    end

    // State registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wordCnt_q  <= '0;
            partCnt_q  <= PART_FIRST;
            roPhase_q  <= '0;
            asm_q      <= '0;
            stage_q    <= '0;
            stageDrv_q <= 1'b0;
            dqOut      <= '0;
            drive_q    <= 1'b0;
        end else begin
            wordCnt_q  <= wordCnt_d;
            partCnt_q  <= partCnt_d;
            roPhase_q  <= roPhase_d;
            asm_q      <= asm_d;
            stage_q    <= stage_d;
            stageDrv_q <= stageDrv_d;
            dqOut      <= dqOut_d;
            drive_q    <= drive_d;
        end
    end

    // Output enable gates the pins without waiting for a clock edge
    assign dqOeN = outputEnableN || !drive_q;

    // Completed words wait here until the array accepts them
    dps_fifo #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .inValid  (wordDone),
        .inReady  (writeReady),
        .inData   ({wordCnt_d, asm_d}),
        .outValid (fifoValid),
        .outReady (arrayReady),
        .outData  (fifoData)
    );

    // Cell array; reads see only words already drained
    dps_array #(
        .ADDR_W (ADDR_W)
    ) u_array (
        .mclk      (mclk),
        .arrayHold (arrayHold),
        .wrValid   (fifoValid),
        .wrReady   (arrayReady),
        .wrAddr    (fifoData[FW-1:DATA_W]),
        .wrData    (fifoData[DATA_W-1:0]),
        .rdAddr    (wordCnt_d),
        .rdData    (rdData)
    );

    // Checks on the port's behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_write_floats: assert property (!pipe && writeCyc ##1 !pipe |-> !drive_q)
        else $error("write cycle drove outputs");
    a_pipe_delay: assert property (pipe && chipSelectN ##1 pipe ##1 pipe |-> !drive_q)
        else $error("pipelined deselect not one cycle late");
    a_pipe_read: assert property (pipe && !chipSelectN && readWriteN ##1 pipe ##1 pipe |-> drive_q)
        else $error("pipelined read not one cycle late");
    a_oe_float: assert property (outputEnableN |-> dqOeN)
        else $error("outputs driven with enable high");
    a_prev_ctrl: assert property (!pipe ##1 !pipe |-> drive_q == $past(!chipSelectN && readWriteN))
        else $error("output state not from previous controls");
    a_cnt_clear: assert property (!counter_clear_n |=> wordCnt_q == '0 && partCnt_q == $past(partStart))
        else $error("counter not cleared");
    a_cnt_load: assert property (counter_clear_n && !address_strobe_n && !count_advance_n
                                 |=> wordCnt_q == $past(addrIn))
        else $error("address not loaded");
    a_cnt_hold: assert property (counter_clear_n && address_strobe_n && count_advance_n
                                 |=> $stable(wordCnt_q) && $stable(partCnt_q))
        else $error("counter moved during hold");
    // Chip select is left out on purpose: stepping must not depend on it
    a_cnt_step: assert property (counter_clear_n && address_strobe_n && !count_advance_n &&
                                 widthMode == DPS_X36
                                 |=> wordCnt_q == $past(wordCnt_q) + 1'b1)
        else $error("counter did not increment");
    // First lane step stays inside the word
    a_x18_word: assert property (counter_clear_n && address_strobe_n && !count_advance_n &&
                                 widthMode == DPS_X18 && !byte_order_select && partCnt_q == PART_FIRST
                                 |=> partCnt_q == PART_LAST_X18 && $stable(wordCnt_q))
        else $error("x18 word not two cycles");
    // Stepping off the word's last lane carries into the word address
    a_lane_wrap: assert property (counter_clear_n && address_strobe_n && !count_advance_n &&
                                  widthMode != DPS_X36 && partCnt_q == partEnd
                                  |=> partCnt_q == $past(partStart) && wordCnt_q == $past(wordCnt_q) + 1'b1)
        else $error("word did not carry after last lane");
    a_ro_x36: assert property (roCond && !chipSelectN && !pipe && widthMode == DPS_X36
                               |=> dqOut[RO_X36_LSB +: ADDR_W] == wordCnt_q)
        else $error("counter readout wrong");
    a_x18_lanes: assert property (!chipSelectN && readWriteN && !pipe && widthMode == DPS_X18
                                  |=> dqOut[DATA_W-1:HALF_W] == '0)
        else $error("unused lanes not quiet");
    a_x9_extend: assert property ((roCond && !pipe && widthMode == DPS_X9)[*3]
                                  |=> dqOut[LANE_W-1:RO_BA_BIT] == $past(dqOut[LANE_W-1:RO_BA_BIT]))
        else $error("x9 final readout part not extended");

    c_word_push: cover property (wordDone && writeReady);
    c_x9_readout: cover property ((roCond && widthMode == DPS_X9)[*3]);
    c_pipe_read: cover property (pipe && freshDrv ##2 drive_q);
    c_fifo_full: cover property (!writeReady);
endmodule
`default_nettype wire

// file: sim/dps_host_model.sv
// Host model standing on the far side of one SRAM port.
// Assumes the bench calls op once per cycle; controls change 1 ns after the edge.
`timescale 1ns/10ps
`default_nettype none
module dps_host_model
    import dps_pkg::*;
(
    input  wire logic                  mclk,
    output var  logic                  chipSelectN,
    output var  logic                  readWriteN,
    output var  logic                  outputEnableN,
    output var  logic                  address_strobe_n,
    output var  logic                  count_advance_n,
    output var  logic                  counter_clear_n,
    output var  logic [ADDR_W_DEF-1:0] addrIn,
    output var  logic [DATA_W-1:0]     dqIn,
    input  wire logic [DATA_W-1:0]     dqOut,
    input  wire logic                  dqOeN
);
    logic [DATA_W-1:0] hostData; // Last value the host drove
    logic              hostDrv;  // Host drives the data lines

    // Wire level: device, host, or the inverse of the last host value
    always_comb dqIn = !dqOeN ? dqOut : (hostDrv ? hostData : ~hostData);

    // Idle, deselected, output enable low
    initial begin
        {chipSelectN, readWriteN, outputEnableN} = 3'b110;
        {address_strobe_n, count_advance_n, counter_clear_n} = 3'b111;
        addrIn = '0;
        hostData = '0;
        hostDrv = 1'b0;
    end

    // One cycle; c = {select, read/write, strobe, advance, clear}
    task automatic op(input logic [4:0] c, input logic [ADDR_W_DEF-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        #1;
        {chipSelectN, readWriteN, address_strobe_n, count_advance_n, counter_clear_n} = c;
        addrIn = a;
        hostDrv = !c[4] && !c[3];
        if (hostDrv) begin
            hostData = d;
        end
    endtask

    // Asynchronous output enable
    task automatic oe(input logic v);
        outputEnableN = v;
    endtask
endmodule
`default_nettype wire

// file: sim/dual_port_sram_port_counter_busmatch_bench.sv
// Self-checking bench of the SRAM port controller.
// Assumes the host model drives the port; expected reads queue in order.
`timescale 1ns/10ps
`default_nettype none
module dual_port_sram_port_counter_busmatch_bench
    import dps_pkg::*;
();
    localparam logic [4:0] WR = 5'b00001, WI = 5'b00101, RL = 5'b01001, RI = 5'b01101;
    localparam logic [4:0] RH = 5'b01111, RO = 5'b01011, DL = 5'b11001, DI = 5'b11101;
    localparam logic [4:0] RC = 5'b01000, ID = 5'b11111;
    logic mclk, rst_n, arrayHold, writeReady, dqOeN;
    logic chipSelectN, readWriteN, outputEnableN, address_strobe_n;
    logic count_advance_n, counter_clear_n, bus_match_select, widthSelect;
    logic byte_order_select, flow_or_pipeline_select;
    logic [ADDR_W_DEF-1:0] addrIn;
    logic [DATA_W-1:0]     dqIn, dqOut;
    logic [DATA_W-1:0]     mem [int];  // Expected array contents
    logic [DATA_W-1:0]     expQ [$];   // Expected driven values
    logic [31:0]           seed = 32'hf0a720fc;
    int                    fails = 0, check_count = 0, cycles = 0;

    dps_port_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .chipSelectN(chipSelectN),
        .readWriteN(readWriteN), .outputEnableN(outputEnableN), .address_strobe_n(address_strobe_n),
        .count_advance_n(count_advance_n), .counter_clear_n(counter_clear_n),
        .bus_match_select(bus_match_select), .widthSelect(widthSelect),
        .byte_order_select(byte_order_select), .flow_or_pipeline_select(flow_or_pipeline_select),
        .addrIn(addrIn), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN), .arrayHold(arrayHold),
        .writeReady(writeReady));
    dps_host_model i_host (.mclk(mclk), .chipSelectN(chipSelectN), .readWriteN(readWriteN),
        .outputEnableN(outputEnableN), .address_strobe_n(address_strobe_n),
        .count_advance_n(count_advance_n), .counter_clear_n(counter_clear_n),
        .addrIn(addrIn), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN));

    // Clock, 4 ns period
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Random word from the shift register
    function automatic logic [DATA_W-1:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return {seed[3:0], seed};
    endfunction

    // Compare and report
    task automatic chk(input logic [DATA_W-1:0] s, e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("unexpected at %0t: seen %h, expected %h", $time, s, e);
        end
    endtask
    task automatic chk1(input logic s, e);
        chk({35'h0, s}, {35'h0, e});
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic idle();
        i_host.op(ID, '0, '0);
    endtask
    task automatic wr(input logic [ADDR_W_DEF-1:0] a, input logic [DATA_W-1:0] d);
        i_host.op(WR, a, d);
        mem[a] = d;
    endtask
    task automatic rd(input logic [ADDR_W_DEF-1:0] a, input logic [4:0] c, input logic [DATA_W-1:0] e);
        i_host.op(c, a, '0);
        expQ.push_back(e);
    endtask
    // Let a pipelined read leave, change widths, then two quiet cycles before use
    task automatic cfg(input logic [3:0] c);
        idle();
        idle();
        {bus_match_select, widthSelect, byte_order_select, flow_or_pipeline_select} = c;
        idle();
        idle();
    endtask
    // Drive window of one read followed by deselects
    task automatic lat(input logic pipe);
        rd(15'h4, RL, mem[4]);
        idle();
        chk1(dqOeN, pipe);
        idle();
        chk1(dqOeN, !pipe);
        idle();
        chk1(dqOeN, 1'b1);
    endtask

    // Every driven cycle takes the oldest expectation
    always @(negedge mclk) begin
        if (rst_n && dqOeN === 1'b0) begin
            if (expQ.size() == 0) begin
                // Pins driven with no read outstanding
                chk1(dqOeN, 1'b1);
            end else begin
                chk(dqOut, expQ.pop_front());
            end
        end
    end

    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            wrap_up();
        end
    end

    initial begin
        logic [DATA_W-1:0]     w;
        logic [ADDR_W_DEF-1:0] a;
        rst_n = 1'b0;
        arrayHold = 1'b0;
        {bus_match_select, widthSelect, byte_order_select, flow_or_pipeline_select} = 4'h0;
        repeat (16) @(posedge mclk);
        #1;
        chk1(dqOeN, 1'b1);
        chk(dqOut, '0);
        chk1(writeReady, 1'b0);
        rst_n = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk1(writeReady, 1'b1);
        // Fill the buffer with the array stalled, then drain
        arrayHold = 1'b1;
        for (int i = 0; i < 8; i++) wr(15'(i), rnd());
        idle();
        idle();
        chk1(writeReady, 1'b0);
        arrayHold = 1'b0;
        for (int n = 0; n < 20 && writeReady !== 1'b1; n++) idle();
        chk1(writeReady, 1'b1);
        idle();
        for (int i = 0; i < 8; i++) rd(15'(i), RL, mem[i]);
        rd(15'h5, RL, mem[5]);
        rd(15'h0, RI, mem[6]);
        rd(15'h0, RH, mem[6]);
        i_host.op(DL, 15'h2, '0);
        i_host.op(DI, 15'h0, '0);
        rd(15'h0, RH, mem[3]);
        rd(15'h7, RC, mem[0]);
        rd(15'h7, RI, mem[1]);
        idle();
        lat(1'b0);
        // Rewrite the location held through the no-op cycles
        wr(15'h4, mem[4]);
        // Output enable floats the pins between edges
        i_host.oe(1'b1);
        i_host.op(RL, 15'h1, '0);
        idle();
        chk1(dqOeN, 1'b1);
        expQ.push_back(mem[1]);
        i_host.oe(1'b0);
        #0.1 chk1(dqOeN, 1'b0);
        cfg(4'h1);
        lat(1'b1);
        for (int i = 7; i >= 0; i--) rd(15'(i), RL, mem[i]);
        // Word lanes, little endian
        cfg(4'h8);
        w = rnd();
        i_host.op(WR, 15'h9, {18'h0, w[17:0]});
        i_host.op(WI, 15'h0, {18'h0, w[35:18]});
        idle();
        rd(15'h9, RL, {18'h0, w[17:0]});
        rd(15'h0, RI, {18'h0, w[35:18]});
        i_host.op(DI, 15'h0, '0);
        i_host.op(DL, 15'h9, '0);
        i_host.op(DI, 15'h0, '0);
        for (int k = 0; k < 2; k++) rd(15'h3, RO, {18'h0, 15'h9, 1'b1, 2'h0});
        // Byte lanes, big endian, then counter readout
        cfg(4'he);
        w = rnd();
        for (int k = 3; k >= 0; k--) i_host.op(k == 3 ? WR : WI, 15'ha, {27'h0, w[k*9+:9]});
        cfg(4'hc);
        a = 15'h5a3c;
        i_host.op(DL, a, '0);
        rd(15'h0, RO, {27'h0, a[14:6]});
        for (int k = 0; k < 2; k++) rd(15'h0, RO, {27'h0, a[5:0], 3'h0});
        cfg(4'h0);
        rd(15'ha, RL, w);
        rd(15'h0, RO, {18'h0, 15'ha, 3'h0});
        repeat (3) idle();
        chk(DATA_W'(expQ.size()), '0);
        wrap_up();
    end
endmodule
`default_nettype wire
